// File: src/pmd_consts.svh
// How it works
// - A set disable bit stops the clock delivered to its peripheral, leaving it in lowest power.
// - While a peripheral is off its register writes are dropped and its read data is invalid.
// - Writing one to a disable bit turns the peripheral off, writing zero turns it on again.
// - Every disable bit resets to zero, so every peripheral leaves reset running.
// - A locked write to a disable register completes without error and changes nothing.
// - Bit 11 of the control register is the lock: one blocks disable writes, zero allows them.
// - Register one: bit 0 converter, bit 12 voltage reference, bit 20 voltage detector.
// - Register two: bits 0 to 2 comparators one to three, bits 24 to 27 logic cells one to four.
// - Register three: bits 8, 9 and 10 gate multi-output capture/compare units one to three.
// - Register three: bits 11 to 16 gate single-output capture/compare units four to nine.
// - Register four: bits 0, 1 and 2 gate general timers one, two and three.
// - Register five: bit 0 gates serial port one.
`ifndef PMD_CONSTS_SVH
`define PMD_CONSTS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define PMD_CTRL_OFS     8'h00
`define PMD_ONE_OFS      8'h10
`define PMD_TWO_OFS      8'h20
`define PMD_THREE_OFS    8'h30
`define PMD_FOUR_OFS     8'h40
`define PMD_FIVE_OFS     8'h50
`define PMD_STATUS_OFS   8'h60

// ****************************************
// field positions
// ****************************************
`define PMD_LOCK_BIT     11
`define PMD_CONV_BIT     0
`define PMD_VREF_BIT     12
`define PMD_VDET_BIT     20
`define PMD_CMP_LSB      0
`define PMD_CELL_LSB     24
`define PMD_CAP_LSB      8
`define PMD_TMR_LSB      0
`define PMD_SER_BIT      0
`define PMD_NUM_CMP      3
`define PMD_NUM_CELL     4
`define PMD_NUM_CAP      9
`define PMD_NUM_TMR      3
`define PMD_NUM_PERIPH   23

// ****************************************
// writable masks and reset values
// ****************************************
`define PMD_ONE_MASK     32'h0010_1001
`define PMD_TWO_MASK     32'h0F00_0007
`define PMD_THREE_MASK   32'h0001_FF00
`define PMD_FOUR_MASK    32'h0000_0007
`define PMD_FIVE_MASK    32'h0000_0001
`define PMD_RST_VAL      32'h0000_0000
`define PMD_LOCK_RST     1'b0

`endif

// File: src/pmd_pkg.sv
package pmd_pkg;

	// one bit per gated peripheral
	typedef logic [22:0] periph_vec_t;

	// position of each peripheral in the gated vectors
	typedef enum logic [4:0] {
		CONVERTER      = 5'b00000,
		VOLT_REF       = 5'b00001,
		VOLT_DETECT    = 5'b00010,
		COMPARATOR_1   = 5'b00011,
		LOGIC_CELL_1   = 5'b00110,
		CAPCOMP_1      = 5'b01010,
		CAPCOMP_4      = 5'b01101,
		GEN_TIMER_1    = 5'b10011,
		SERIAL_PORT_1  = 5'b10110
	} periph_idx_t;

endpackage : pmd_pkg

// File: src/clk_gate_cell.sv
`timescale 1ns/1ps
module clk_gate_cell (
	input  wire logic clk_in,
	input  wire logic enable,
	output logic      clk_out
);

	logic enable_latched;

	// transparent only while the clock is low, so the enable settles
	// before the high phase and no runt pulse can escape
	always_latch begin
		if (!clk_in) begin
			enable_latched <= enable;
		end
	end

	assign clk_out = clk_in & enable_latched;

endmodule : clk_gate_cell

// File: src/disable_field_reg.sv
`timescale 1ns/1ps
`include "pmd_consts.svh"
module disable_field_reg #(
	parameter logic [31:0] MASK = 32'h0000_0000
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        wr_en,
	input  wire logic        lock,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  strobe,
	output logic      [31:0] value
);

	logic [31:0] lane_mask;

	// byte strobes widened to a bit mask, limited to implemented bits
	assign lane_mask = {{8{strobe[3]}}, {8{strobe[2]}}, {8{strobe[1]}}, {8{strobe[0]}}} & MASK;

	// a locked write is accepted by the bus but leaves the bits alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= `PMD_RST_VAL;
		end else if (wr_en && !lock) begin
			value <= (value & ~lane_mask) | (wdata & lane_mask);
		end
	end

endmodule : disable_field_reg

// File: src/peripheral_clock_gate_ctrl.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "pmd_consts.svh"
module peripheral_clock_gate_ctrl (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [7:0]           paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 unlock_granted,
	input  wire pmd_pkg::periph_vec_t periph_wr_req,
	output pmd_pkg::periph_vec_t      periph_clk,
	output pmd_pkg::periph_vec_t      periph_reg_en,
	output pmd_pkg::periph_vec_t      periph_wr_en,
	output pmd_pkg::periph_vec_t      periph_rd_valid,
	output logic                      disable_regs_lock
);

	// ****************************************
	// bus phase decode
	// ****************************************
	logic                 setup_phase;
	logic                 wr_access;
	logic                 sel_ctrl;
	logic                 sel_one;
	logic                 sel_two;
	logic                 sel_three;
	logic                 sel_four;
	logic                 sel_five;
	logic                 sel_status;
	logic                 unmapped;
	logic [31:0]          next_rdata;
	logic [31:0]          disable_reg_one;
	logic [31:0]          disable_reg_two;
	logic [31:0]          disable_reg_three;
	logic [31:0]          disable_reg_four;
	logic [31:0]          disable_reg_five;
	logic [31:0]          disable_control_reg;
	logic [31:0]          clock_status;
	pmd_pkg::periph_vec_t off;
	pmd_pkg::periph_vec_t clk_on;

	// zero wait states: every access completes in its first access cycle
	assign pready      = 1'b1;
	assign setup_phase = psel & ~penable;
	assign wr_access   = psel & penable & pwrite;

	// address decode, one hit at most
	always_comb begin
		sel_ctrl   = 1'b0;
		sel_one    = 1'b0;
		sel_two    = 1'b0;
		sel_three  = 1'b0;
		sel_four   = 1'b0;
		sel_five   = 1'b0;
		sel_status = 1'b0;
		unmapped   = 1'b0;
		if (paddr == `PMD_CTRL_OFS) begin
			sel_ctrl = 1'b1;
		end else if (paddr == `PMD_ONE_OFS) begin
			sel_one = 1'b1;
		end else if (paddr == `PMD_TWO_OFS) begin
			sel_two = 1'b1;
		end else if (paddr == `PMD_THREE_OFS) begin
			sel_three = 1'b1;
		end else if (paddr == `PMD_FOUR_OFS) begin
			sel_four = 1'b1;
		end else if (paddr == `PMD_FIVE_OFS) begin
			sel_five = 1'b1;
		end else if (paddr == `PMD_STATUS_OFS) begin
			sel_status = 1'b1;
		end else begin
			unmapped = 1'b1;
		end
	end

	// ****************************************
	// lock bit
	// ****************************************

	// without a granted unlock the write is swallowed silently, not errored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disable_regs_lock <= `PMD_LOCK_RST;
		end else if (wr_access && sel_ctrl && pstrb[1] && unlock_granted) begin
			disable_regs_lock <= pwdata[`PMD_LOCK_BIT];
		end
	end

	// lock is the only implemented control bit
	always_comb begin
		disable_control_reg = 32'h0000_0000;
		disable_control_reg[`PMD_LOCK_BIT] = disable_regs_lock;
	end

	// ****************************************
	// disable registers
	// ****************************************
	disable_field_reg #(.MASK(`PMD_ONE_MASK)) u_reg_one (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_access & sel_one),
		.lock    (disable_regs_lock),
		.wdata   (pwdata),
		.strobe  (pstrb),
		.value   (disable_reg_one)
	);

	disable_field_reg #(.MASK(`PMD_TWO_MASK)) u_reg_two (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_access & sel_two),
		.lock    (disable_regs_lock),
		.wdata   (pwdata),
		.strobe  (pstrb),
		.value   (disable_reg_two)
	);

	disable_field_reg #(.MASK(`PMD_THREE_MASK)) u_reg_three (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_access & sel_three),
		.lock    (disable_regs_lock),
		.wdata   (pwdata),
		.strobe  (pstrb),
		.value   (disable_reg_three)
	);

	disable_field_reg #(.MASK(`PMD_FOUR_MASK)) u_reg_four (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_access & sel_four),
		.lock    (disable_regs_lock),
		.wdata   (pwdata),
		.strobe  (pstrb),
		.value   (disable_reg_four)
	);

	disable_field_reg #(.MASK(`PMD_FIVE_MASK)) u_reg_five (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_access & sel_five),
		.lock    (disable_regs_lock),
		.wdata   (pwdata),
		.strobe  (pstrb),
		.value   (disable_reg_five)
	);

	// ****************************************
	// bit map from registers to peripherals
	// ****************************************
	always_comb begin
		off = '0;
		off[pmd_pkg::CONVERTER]   = disable_reg_one[`PMD_CONV_BIT];
		off[pmd_pkg::VOLT_REF]    = disable_reg_one[`PMD_VREF_BIT];
		off[pmd_pkg::VOLT_DETECT] = disable_reg_one[`PMD_VDET_BIT];
		for (int i = 0; i < `PMD_NUM_CMP; i++) begin
			off[pmd_pkg::COMPARATOR_1 + i] = disable_reg_two[`PMD_CMP_LSB + i];
		end
		for (int i = 0; i < `PMD_NUM_CELL; i++) begin
			off[pmd_pkg::LOGIC_CELL_1 + i] = disable_reg_two[`PMD_CELL_LSB + i];
		end
		// multi-output units take the first three bits, single-output the next six
		for (int i = 0; i < `PMD_NUM_CAP; i++) begin
			off[pmd_pkg::CAPCOMP_1 + i] = disable_reg_three[`PMD_CAP_LSB + i];
		end
		for (int i = 0; i < `PMD_NUM_TMR; i++) begin
			off[pmd_pkg::GEN_TIMER_1 + i] = disable_reg_four[`PMD_TMR_LSB + i];
		end
		off[pmd_pkg::SERIAL_PORT_1] = disable_reg_five[`PMD_SER_BIT];
	end

	// ****************************************
	// gated clocks and register access
	// ****************************************
	for (genvar g = 0; g < `PMD_NUM_PERIPH; g++) begin : g_gate
		clk_gate_cell u_gate (
			.clk_in  (pclk),
			.enable  (~off[g]),
			.clk_out (periph_clk[g])
		);
	end

	// a disabled peripheral sees no write strobe and must flag reads as junk
	assign periph_reg_en   = ~off;
	assign periph_wr_en    = periph_wr_req & ~off;
	assign periph_rd_valid = ~off;

	// clock-running status, one cycle behind the disable bits, as the
	// gate itself lags the bit by the latch's low phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_on <= '1;
		end else begin
			clk_on <= ~off;
		end
	end

	assign clock_status = {9'h000, clk_on};

	// ****************************************
	// read data and error answer
	// ****************************************
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (sel_ctrl) begin
			next_rdata = disable_control_reg;
		end else if (sel_one) begin
			next_rdata = disable_reg_one;
		end else if (sel_two) begin
			next_rdata = disable_reg_two;
		end else if (sel_three) begin
			next_rdata = disable_reg_three;
		end else if (sel_four) begin
			next_rdata = disable_reg_four;
		end else if (sel_five) begin
			next_rdata = disable_reg_five;
		end else if (sel_status) begin
			next_rdata = clock_status;
		end
	end

	// captured in the setup cycle so the access cycle shows flop outputs;
	// a locked write still answers without error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= unmapped;
		end else begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_write_one_set;
		wr_access && sel_one && !disable_regs_lock && (pstrb == 4'hF)
			&& pwdata[`PMD_CONV_BIT];
	endsequence

	sequence s_clock_dropped;
		##2 !clock_status[pmd_pkg::CONVERTER];
	endsequence

	AST_LOCKED_WRITE_HOLDS: assert property (
		(wr_access && sel_three && disable_regs_lock) |=> $stable(disable_reg_three))
		else $error("locked write changed disable register three");

	AST_WRITE_ZERO_ENABLES: assert property (
		(wr_access && sel_four && !disable_regs_lock && pstrb[0] && !pwdata[0])
			|=> !off[pmd_pkg::GEN_TIMER_1])
		else $error("writing zero did not enable timer one");

	AST_LOCK_NEEDS_GRANT: assert property (
		(wr_access && sel_ctrl && !unlock_granted) |=> $stable(disable_regs_lock))
		else $error("lock changed without unlock grant");

	AST_LOCK_TAKES_BIT: assert property (
		(wr_access && sel_ctrl && unlock_granted && pstrb[1])
			|=> (disable_regs_lock == $past(pwdata[`PMD_LOCK_BIT])))
		else $error("lock bit did not follow write data bit 11");

	AST_LOCKED_NO_ERROR: assert property (
		(setup_phase && pwrite && sel_two && disable_regs_lock) |=> !pslverr)
		else $error("locked write answered with an error");

	AST_WRITE_STROBE_BLOCKED: assert property (
		off[pmd_pkg::SERIAL_PORT_1] |-> !periph_wr_en[pmd_pkg::SERIAL_PORT_1]
			&& !periph_rd_valid[pmd_pkg::SERIAL_PORT_1])
		else $error("disabled serial port still sees register access");

	AST_CLOCK_STOPS: assert property (
		s_write_one_set |-> s_clock_dropped)
		else $error("converter clock still running two cycles after disable");

	AST_CELL_MAP: assert property (
		$rose(disable_reg_two[`PMD_CELL_LSB + 3]) |-> off[pmd_pkg::LOGIC_CELL_1 + 3]
			&& !$past(off[pmd_pkg::LOGIC_CELL_1 + 3]))
		else $error("logic cell four not gated by register two bit 27");

	AST_CAPCOMP_MAP: assert property (
		(off[pmd_pkg::CAPCOMP_4 + 5] == disable_reg_three[16])
			&& (off[pmd_pkg::CAPCOMP_4] == disable_reg_three[11]))
		else $error("single-output capture/compare bits misplaced");

	sequence s_locked_disable_write;
		wr_access && disable_regs_lock
			&& (sel_one || sel_two || sel_three || sel_four || sel_five);
	endsequence

	sequence s_regs_frozen;
		$stable(disable_reg_one) && $stable(disable_reg_two) && $stable(disable_reg_three)
			&& $stable(disable_reg_four) && $stable(disable_reg_five);
	endsequence

	AST_LOCKED_REGS_FROZEN: assert property (
		s_locked_disable_write |=> s_regs_frozen)
		else $error("locked write changed a disable register");

	AST_WRITE_ONE_DISABLES: assert property (
		(wr_access && sel_four && !disable_regs_lock && pstrb[0] && pwdata[0])
			|=> off[pmd_pkg::GEN_TIMER_1])
		else $error("writing one did not disable timer one");

	AST_STATUS_LAGS: assert property (
		clk_on == ~$past(off))
		else $error("clock status does not trail the disable bits by one cycle");

	AST_FIRST_REG_MAP: assert property (
		(off[pmd_pkg::CONVERTER] == disable_reg_one[0])
			&& (off[pmd_pkg::VOLT_REF] == disable_reg_one[12])
			&& (off[pmd_pkg::VOLT_DETECT] == disable_reg_one[20]))
		else $error("first register bits misplaced");

	AST_MULTI_CAPCOMP_MAP: assert property (
		off[12:10] == disable_reg_three[10:8])
		else $error("multi-output capture/compare bits misplaced");

	AST_TIMER_SERIAL_MAP: assert property (
		(off[21:19] == disable_reg_four[2:0]) && (off[22] == disable_reg_five[0]))
		else $error("timer or serial port bits misplaced");

	AST_ACCESS_FOLLOWS_GATE: assert property (
		off[pmd_pkg::CONVERTER] |-> !periph_reg_en[pmd_pkg::CONVERTER]
			&& !periph_wr_en[pmd_pkg::CONVERTER])
		else $error("disabled converter still has register access");

	// sampled on the falling edge: the gated clock only shows in the high
	// phase, and a bit set at the last rising edge may still pass that phase
	AST_GATED_CLOCK_LOW: assert property (
		@(negedge pclk) (off[0] && $past(off[0])) |-> !periph_clk[0])
		else $error("converter clock ran while held disabled");

endmodule : peripheral_clock_gate_ctrl

// File: testbench/periph_model.sv
`timescale 1ns/1ps
// ****************************************
// peripheral stand-ins
// ****************************************
module periph_model (
	input  wire pmd_pkg::periph_vec_t periph_clk,
	input  wire logic                 clear,
	input  wire pmd_pkg::periph_vec_t req,
	output pmd_pkg::periph_vec_t      periph_wr_req,
	output pmd_pkg::periph_vec_t      clk_seen
);
	// each stand-in asks for its register writes when the bench says so
	assign periph_wr_req = req;

	// one flag per peripheral: its clock rose since the last clear
	for (genvar i = 0; i < 23; i++) begin : g_seen
		always_ff @(posedge periph_clk[i] or posedge clear) begin
			if (clear)
				clk_seen[i] <= 1'b0;
			else
				clk_seen[i] <= 1'b1;
		end
	end
endmodule : periph_model

// File: testbench/tb.sv
`timescale 1ns/1ps
`include "pmd_consts.svh"
module tb;
	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, s_rdata;
	logic [3:0]           pstrb;
	logic                 unlock_granted, clear, s_err, disable_regs_lock;
	pmd_pkg::periph_vec_t periph_wr_req, periph_clk, periph_reg_en, req;
	pmd_pkg::periph_vec_t periph_wr_en, periph_rd_valid, clk_seen;
	int                   errors, total_checks, cycles;
	localparam pmd_pkg::periph_vec_t ALL = 23'h7FFFFF;

	peripheral_clock_gate_ctrl peripheral_clock_gate_ctrl_i (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.unlock_granted(unlock_granted), .periph_wr_req(periph_wr_req),
		.periph_clk(periph_clk), .periph_reg_en(periph_reg_en), .periph_wr_en(periph_wr_en),
		.periph_rd_valid(periph_rd_valid), .disable_regs_lock(disable_regs_lock));
	periph_model periph_model_i (.periph_clk(periph_clk), .clear(clear), .req(req),
		.periph_wr_req(periph_wr_req), .clk_seen(clk_seen));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// answer captured at the sampling edge itself, free of update races
	always @(posedge pclk) begin
		s_rdata <= prdata;
		s_err <= pslverr;
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			test_done();
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
		rd = s_rdata;
		err = s_err;
	endtask : apb

	// {byte address, bit} of the disable bit for vector index i
	function automatic logic [15:0] loc(input int i);
		if (i < 1) return 16'h1000;
		if (i < 2) return 16'h100C;
		if (i < 3) return 16'h1014;
		if (i < 6) return {8'h20, 8'(i - 3)};
		if (i < 10) return {8'h20, 8'(i + 18)};
		if (i < 19) return {8'h30, 8'(i - 2)};
		if (i < 22) return {8'h40, 8'(i - 19)};
		return 16'h5000;
	endfunction : loc

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_reset();
		logic [31:0] rd;
		logic        er;
		for (int i = 0; i < 6; i++) begin
			apb(8'(i * 16), 1'b0, 32'h0, 4'h0, rd, er);
			check(rd, 32'h0, "reset value");
		end
		apb(8'h60, 1'b0, 32'h0, 4'h0, rd, er);
		check(rd, 32'h007FFFFF, "clocks after reset");
		check({31'h0, pready}, 32'h1, "ready stands high");
		check(32'(periph_reg_en), 32'(ALL), "enables after reset");
		$display("test reset done");
	endtask : test_reset

	task automatic test_map();
		logic [31:0]          rd;
		logic                 er;
		logic [7:0]           a, b;
		pmd_pkg::periph_vec_t ev;
		for (int i = 0; i < 23; i++) begin
			{a, b} = loc(i);
			ev = ALL & ~(23'h1 << i);
			apb(a, 1'b1, 32'h1 << b, 4'hF, rd, er);
			check(32'(periph_reg_en), 32'(ev), "one peripheral off");
			@(posedge pclk);
			clear <= 1'b1;
			@(posedge pclk);
			clear <= 1'b0;
			repeat (3) @(posedge pclk);
			#1;
			check(32'(clk_seen), 32'(ev), "only that clock stopped");
			apb(a, 1'b0, 32'h0, 4'h0, rd, er);
			check(rd, 32'h1 << b, "disable bit readback");
			apb(8'h60, 1'b0, 32'h0, 4'h0, rd, er);
			check(rd, 32'(ev), "clock status");
			apb(a, 1'b1, 32'h0, 4'hF, rd, er);
			check(32'(periph_reg_en), 32'(ALL), "peripheral back on");
		end
		$display("test map done");
	endtask : test_map

	task automatic test_access();
		logic [31:0] rd;
		logic        er;
		logic [31:0] m [5];
		m = '{`PMD_ONE_MASK, `PMD_TWO_MASK, `PMD_THREE_MASK, `PMD_FOUR_MASK, `PMD_FIVE_MASK};
		@(posedge pclk);
		req <= ALL;
		apb(8'h30, 1'b1, 32'h0000_0800, 4'hF, rd, er);
		check(32'(periph_wr_en), 32'(ALL & ~(23'h1 << 13)), "writes blocked");
		check(32'(periph_rd_valid), 32'(ALL & ~(23'h1 << 13)), "reads invalid");
		for (int i = 0; i < 5; i++) begin
			apb(8'((i + 1) * 16), 1'b1, 32'hFFFF_FFFF, 4'hF, rd, er);
			apb(8'((i + 1) * 16), 1'b0, 32'h0, 4'h0, rd, er);
			check(rd, m[i], "only gate bits stick");
			apb(8'((i + 1) * 16), 1'b1, 32'h0, 4'hF, rd, er);
		end
		check(32'(periph_wr_en), 32'(ALL), "writes pass again");
		@(posedge pclk);
		req <= '0;
		$display("test access done");
	endtask : test_access

	task automatic test_lock();
		logic [31:0] rd;
		logic        er;
		apb(8'h00, 1'b1, 32'h0000_0800, 4'h2, rd, er);
		check(32'(disable_regs_lock), 32'h0, "lock needs unlock");
		@(posedge pclk);
		unlock_granted <= 1'b1;
		apb(8'h00, 1'b1, 32'h0000_0800, 4'h2, rd, er);
		check(32'(disable_regs_lock), 32'h1, "lock set");
		apb(8'h00, 1'b0, 32'h0, 4'h0, rd, er);
		check(rd, 32'h0000_0800, "lock readback");
		apb(8'h10, 1'b1, 32'h0000_0001, 4'hF, rd, er);
		check(32'(er), 32'h0, "locked write no error");
		apb(8'h10, 1'b0, 32'h0, 4'h0, rd, er);
		check(rd, 32'h0, "locked write ignored");
		for (int i = 2; i < 4; i++) begin
			apb(8'(i * 16), 1'b1, 32'hFFFF_FFFF, 4'hF, rd, er);
			check({31'h0, er}, 32'h0, "locked write no error");
			apb(8'(i * 16), 1'b0, 32'h0, 4'h0, rd, er);
			check(rd, 32'h0, "locked write ignored");
		end
		apb(8'h00, 1'b1, 32'h0, 4'h2, rd, er);
		check(32'(disable_regs_lock), 32'h0, "lock cleared");
		apb(8'h10, 1'b1, 32'h0000_0001, 4'hF, rd, er);
		check(32'(periph_reg_en[0]), 32'h0, "unlocked write lands");
		apb(8'h10, 1'b1, 32'h0, 4'hF, rd, er);
		@(posedge pclk);
		unlock_granted <= 1'b0;
		$display("test lock done");
	endtask : test_lock

	task automatic test_unmapped();
		logic [31:0] rd;
		logic        er;
		apb(8'h70, 1'b0, 32'h0, 4'h0, rd, er);
		check({31'h0, er}, 32'h1, "unmapped read error");
		check(rd, 32'h0, "unmapped read data");
		apb(8'h70, 1'b1, 32'hFFFF_FFFF, 4'hF, rd, er);
		check(32'(periph_reg_en), 32'(ALL), "unmapped write no effect");
		$display("test unmapped done");
	endtask : test_unmapped

	// reset in mid-run must drop disable bits and lock alike
	task automatic test_midrun_reset();
		logic [31:0] rd;
		logic        er;
		apb(8'h30, 1'b1, 32'hFFFF_FFFF, 4'hF, rd, er);
		@(posedge pclk);
		unlock_granted <= 1'b1;
		apb(8'h00, 1'b1, 32'h0000_0800, 4'h2, rd, er);
		check(32'(disable_regs_lock), 32'h1, "lock set before reset");
		@(posedge pclk);
		presetn <= 1'b0;
		unlock_granted <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		check(32'(disable_regs_lock), 32'h0, "lock after mid-run reset");
		check(32'(periph_reg_en), 32'(ALL), "enables after mid-run reset");
		apb(8'h30, 1'b0, 32'h0, 4'h0, rd, er);
		check(rd, 32'h0, "register three after mid-run reset");
		apb(8'h60, 1'b0, 32'h0, 4'h0, rd, er);
		check(rd, 32'h007FFFFF, "clocks after mid-run reset");
		$display("test midrun reset done");
	endtask : test_midrun_reset

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// reset held four cycles, then the scenarios in turn
	initial begin
		errors = 0;
		total_checks = 0;
		cycles = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, unlock_granted, clear} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		req = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_map();
		test_access();
		test_lock();
		test_unmapped();
		test_midrun_reset();
		test_done();
	end
endmodule : tb
